// [rtl/rpm_pkg.sv]
package rpm_pkg;

  // register offsets
  localparam logic [7:0] KEY_LOW_OFFSET = 8'h47;
  localparam logic [7:0] KEY_HIGH_OFFSET = 8'h48;
  localparam logic [7:0] FLAGS_OFFSET = 8'h49;
  localparam logic [7:0] KEY_RESET = 8'h00;
  // unlock pattern for the shared pin
  localparam logic [7:0] KEY_LOW_UNLOCK = 8'h55;
  localparam logic [7:0] KEY_HIGH_UNLOCK = 8'hAA;
  // flags register bit positions
  localparam int FLAG_SUPPLY_POS = 2;
  localparam int FLAG_WATCHDOG_POS = 1;
  // sequence timing in cpu cycles
  localparam int DELAY_FAST_CYCLES = 512;
  localparam int DELAY_SLOW_CYCLES = 256;
  localparam int FETCH_CYCLES = 2;
  // minimum output pulse, ns, and derived count (rounded up)
  localparam int MIN_OUT_PULSE_NS = 20;
  localparam int CLK_PERIOD_NS = 4;
  localparam int MIN_OUT_PULSE_CYCLES = (MIN_OUT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_ACTIVE,
    SEQ_DELAY,
    SEQ_FETCH
  } rpm_state_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } rpm_bus_t;

endpackage

// [rtl/rpm_reset_pin_manager.sv]
// Behaviour
// RULE1: reset pin is open-drain; low in senses a request, only ever driven low.
// RULE2: outside party holds the pin low for the minimum input pulse width.
// RULE3: external low request is caught asynchronously, with no clock needed.
// RULE4: with supply detector off, board holds pin low until supply is good.
// RULE5: low-supply indication holds a static reset; detector gives the hysteresis.
// RULE6: pin is driven low for the whole supply-drop reset.
// RULE7: a configuration input enables the supply-drop source; disabled means no reset.
// RULE8: watchdog underflow starts reset, pin held low at least minimum output pulse.
// RULE9: illegal opcode or prebyte starts the same reset sequence.
// RULE10: supply-drop reset after watchdog reset wins and clears the watchdog flag.
// RULE11: both pin-function key registers clear to zero on every reset.
// RULE12: each key register accepts one write between resets; reads always work.
// RULE13: with both keys zero the shared pin is the reset pin.
// RULE14: shared pin becomes port A bit 3 output only on 55h and AAh.
// RULE15: once output, software cannot restore the reset function.
// RULE16: internal resets clear both keys, returning the pin to reset function.
// RULE17: pin stays low through the delay phase, whatever the source.
// RULE18: delay is 512 cycles for fast or external clock, 256 for slow.
// RULE19: two cycles of vector fetch follow the delay phase.
// RULE20: any key pattern other than the exact one keeps the reset function.
`timescale 1ns/100ps
`default_nettype none

module rpm_reset_pin_manager #(
  parameter int DELAY_FAST = rpm_pkg::DELAY_FAST_CYCLES,
  parameter int DELAY_SLOW = rpm_pkg::DELAY_SLOW_CYCLES,
  parameter int OUT_PULSE = rpm_pkg::MIN_OUT_PULSE_CYCLES
) (
  // clock and power-on reset
  input wire logic i_mclk,
  input wire logic i_resetn,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // reset sources and configuration
  input wire logic i_supply_low,
  input wire logic i_supply_detector_en,
  input wire logic i_watchdog_underflow,
  input wire logic i_illegal_opcode,
  input wire logic i_slow_clock_sel,
  // shared pin: reset or port A bit 3
  input wire logic i_pin,
  output logic o_pin,
  output logic o_pin_oe,
  input wire logic i_port_a_bit3_output,
  // reset to the core
  output logic o_core_resetn,
  output logic o_pin_is_gpio
);

  localparam int CW = $clog2(DELAY_FAST + 1) + 1;

  // counter width follows the longest phase; pulse and fetch counts must fit too
  // a slow delay above the fast one would turn the oscillator choice upside down
  initial begin
    if (DELAY_FAST < 1) begin
      $error("rpm_reset_pin_manager: fast delay must be at least one cycle");
    end
    if (DELAY_SLOW < 1) begin
      $error("rpm_reset_pin_manager: slow delay must be at least one cycle");
    end
    if (DELAY_SLOW > DELAY_FAST) begin
      $error("rpm_reset_pin_manager: slow delay longer than fast delay");
    end
    if (OUT_PULSE < 1) begin
      $error("rpm_reset_pin_manager: output pulse must be at least one cycle");
    end
    if (OUT_PULSE >= (1 << CW)) begin
      $error("rpm_reset_pin_manager: output pulse does not fit the counter");
    end
    if (rpm_pkg::FETCH_CYCLES >= (1 << CW)) begin
      $error("rpm_reset_pin_manager: fetch phase does not fit the counter");
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // request decode

  rpm_pkg::rpm_bus_t bus;
  rpm_pkg::rpm_state_t state;
  rpm_pkg::rpm_state_t next_state;
  logic [7:0] key_low;
  logic [7:0] key_high;
  logic key_low_done;
  logic key_high_done;
  logic flag_supply;
  logic flag_watchdog;
  logic [CW-1:0] count;
  logic [CW-1:0] next_count;
  logic ext_req_n;
  logic ext_sync1;
  logic ext_sync2;
  logic pin_gpio;
  logic [2:0] oe_hist;
  logic [7:0] flags_word;

  assign bus = '{addr: i_addr, wdata: i_wdata, wr: i_wr, rd: i_rd};

  // gpio mode exact pattern only
  wire unlocked = (key_low == rpm_pkg::KEY_LOW_UNLOCK)
      && (key_high == rpm_pkg::KEY_HIGH_UNLOCK); // RULE14 RULE20
  wire supply_rst = i_supply_low && i_supply_detector_en; // RULE5 RULE7
  wire internal_req = supply_rst || i_watchdog_underflow || i_illegal_opcode; // RULE9
  // external request only counts while the pin has its reset function
  // and while the block is not sinking the pin itself; a board request that
  // overlaps an own pulse is merged into it rather than seen as a new one
  wire self_drive = o_pin_oe || (|oe_hist);
  wire ext_req = ext_sync2 && !pin_gpio && !self_drive; // RULE13 RULE1
  wire any_req = internal_req || ext_req;
  wire key_clear = any_req; // RULE16
  // oscillator choice sets the settle time; the slow clock needs fewer cycles
  wire [CW-1:0] delay_len = i_slow_clock_sel ? CW'(DELAY_SLOW) : CW'(DELAY_FAST); // RULE18

  //////////////////////////////////////////////////////////////////////////////
  // register decode

  wire wr_low = bus.wr && bus.addr == rpm_pkg::KEY_LOW_OFFSET && !key_low_done; // RULE12
  wire wr_high = bus.wr && bus.addr == rpm_pkg::KEY_HIGH_OFFSET && !key_high_done; // RULE12
  wire rd_flags = bus.rd && bus.addr == rpm_pkg::FLAGS_OFFSET;
  // flags word from the bit positions; unused bits read zero
  always_comb begin
    flags_word = 8'h00;
    flags_word[rpm_pkg::FLAG_SUPPLY_POS] = flag_supply;
    flags_word[rpm_pkg::FLAG_WATCHDOG_POS] = flag_watchdog;
  end
  wire [7:0] rd_mux = (bus.addr == rpm_pkg::KEY_LOW_OFFSET) ? key_low
      : (bus.addr == rpm_pkg::KEY_HIGH_OFFSET) ? key_high
      : rd_flags ? flags_word : 8'h00;
  wire seq_busy = state != rpm_pkg::SEQ_IDLE;
  // pin low while active or delay phase, or supply low with the detector enabled
  wire drive_low = supply_rst || state == rpm_pkg::SEQ_ACTIVE
      || state == rpm_pkg::SEQ_DELAY; // RULE6 RULE17 RULE8

  //////////////////////////////////////////////////////////////////////////////
  // asynchronous capture of the external pin

  // low on pin clears the capture without a clock edge, so halt mode still resets
  always_ff @(posedge i_mclk or negedge i_pin) begin
    if (!i_pin) begin
      ext_req_n <= 1'b0; // RULE3 RULE1
    end else begin
      ext_req_n <= 1'b1;
    end
  end

  // only the second stage is read downstream; the first may still be settling
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      ext_sync1 <= 1'b0;
      ext_sync2 <= 1'b0;
    end else begin
      ext_sync1 <= !ext_req_n;
      ext_sync2 <= ext_sync1;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // own-drive shadow

  // the pin reaches ext_sync2 up to three edges after the block lets go,
  // so the mask trails o_pin_oe by as many edges
  // reset value high: the block sinks the pin from power-on
  wire [2:0] oe_src = {oe_hist[1:0], o_pin_oe};
  for (genvar stage = 0; stage < 3; stage++) begin : g_oe_hist
    always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
        oe_hist[stage] <= 1'b1;
      end else begin
        oe_hist[stage] <= oe_src[stage];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // reset sequence

  // idle, active (minimum pulse, then while a source holds), delay, fetch
  // a new request in delay or fetch restarts the active phase
  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      rpm_pkg::SEQ_IDLE: begin
        if (any_req) begin
          next_state = rpm_pkg::SEQ_ACTIVE;
          next_count = CW'(OUT_PULSE);
        end
      end
      rpm_pkg::SEQ_ACTIVE: begin
        // stay active while any source holds; minimum pulse first
        if (count > CW'(1)) begin
          next_count = count - CW'(1); // RULE8
        end else if (!any_req) begin
          next_state = rpm_pkg::SEQ_DELAY;
          next_count = delay_len;
        end
      end
      rpm_pkg::SEQ_DELAY: begin
        if (any_req) begin
          next_state = rpm_pkg::SEQ_ACTIVE;
          next_count = CW'(OUT_PULSE);
        end else if (count > CW'(1)) begin
          next_count = count - CW'(1); // RULE18
        end else begin
          next_state = rpm_pkg::SEQ_FETCH;
          next_count = CW'(rpm_pkg::FETCH_CYCLES);
        end
      end
      rpm_pkg::SEQ_FETCH: begin
        if (any_req) begin
          next_state = rpm_pkg::SEQ_ACTIVE;
          next_count = CW'(OUT_PULSE);
        end else if (count > CW'(1)) begin
          next_count = count - CW'(1); // RULE19
        end else begin
          next_state = rpm_pkg::SEQ_IDLE;
          next_count = '0;
        end
      end
    endcase
  end

  // power-on puts the sequence in its active phase
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state <= rpm_pkg::SEQ_ACTIVE;
      count <= CW'(OUT_PULSE);
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin-function keys

  // any reset event clears keys; power-on also via i_resetn
  // each key has its own lock, so a half-written pair stays half-written
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      key_low <= rpm_pkg::KEY_RESET; // RULE11
      key_low_done <= 1'b0;
    end else if (key_clear) begin
      key_low <= rpm_pkg::KEY_RESET; // RULE11 RULE16
      key_low_done <= 1'b0;
    end else if (wr_low) begin
      // write-once: no other path back to the reset function
      key_low <= bus.wdata; // RULE12 RULE15
      key_low_done <= 1'b1;
    end
  end

  // same lock scheme for the high key
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      key_high <= rpm_pkg::KEY_RESET; // RULE11
      key_high_done <= 1'b0;
    end else if (key_clear) begin
      key_high <= rpm_pkg::KEY_RESET; // RULE11 RULE16
      key_high_done <= 1'b0;
    end else if (wr_high) begin
      key_high <= bus.wdata; // RULE12 RULE15
      key_high_done <= 1'b1;
    end
  end

  // reset-cause flags; a read clears them
  // a new cause in the same cycle as the read wins
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      flag_supply <= 1'b0;
    end else if (supply_rst) begin
      flag_supply <= 1'b1; // RULE10
    end else if (rd_flags) begin
      flag_supply <= 1'b0;
    end
  end

  // supply-drop outranks the watchdog cause and wipes its flag
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      flag_watchdog <= 1'b0;
    end else if (supply_rst) begin
      flag_watchdog <= 1'b0; // RULE10
    end else if (i_watchdog_underflow) begin
      flag_watchdog <= 1'b1;
    end else if (rd_flags) begin
      flag_watchdog <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  // the port owns the pin only while no reset request is pending,
  // so a request takes the pin back at once and never drives it high
  wire next_gpio = unlocked && !any_req; // RULE14 RULE20
  wire next_pin = next_gpio && i_port_a_bit3_output; // RULE1
  wire next_pin_oe = next_gpio || drive_low
      || next_state == rpm_pkg::SEQ_ACTIVE; // RULE6 RULE17
  wire next_core_resetn = !seq_busy && !any_req;
  wire [7:0] next_rdata = bus.rd ? rd_mux : 8'h00;

  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_gpio <= 1'b0; // RULE13
      o_pin_is_gpio <= 1'b0;
      o_pin <= 1'b0;
      o_pin_oe <= 1'b1;
    end else begin
      pin_gpio <= next_gpio; // RULE14 RULE20
      o_pin_is_gpio <= next_gpio;
      o_pin <= next_pin; // RULE1
      o_pin_oe <= next_pin_oe;
    end
  end

  // core held through active, delay and fetch, released one edge after fetch
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_core_resetn <= 1'b0;
    end else begin
      o_core_resetn <= next_core_resetn; // RULE19
    end
  end

  // read data stand for one cycle, zero otherwise
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= next_rdata;
    end
  end

endmodule // rpm_reset_pin_manager

`default_nettype wire

// [testbench/rpm_reset_pin_manager_props.sv]
`timescale 1ns/100ps
`default_nettype none
module rpm_props #(
  parameter int DELAY_SLOW = 4,
  parameter int OUT_PULSE = 5
) (
  // clock, reset, bus
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  // sources
  input wire logic i_supply_low,
  input wire logic i_supply_detector_en,
  input wire logic i_watchdog_underflow,
  input wire logic i_illegal_opcode,
  // pin and core
  input wire logic o_pin,
  input wire logic o_pin_oe,
  input wire logic o_core_resetn,
  input wire logic o_pin_is_gpio
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  logic [15:0] low_cnt;
  wire logic sup_req = i_supply_low && i_supply_detector_en;
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      low_cnt <= 16'h0000;
    end else begin
      low_cnt <= o_core_resetn ? 16'h0000 : low_cnt + 16'h0001;
    end
  end
  pin_only_low_a: assert property (!o_pin_is_gpio |-> !o_pin) else $error("pin high");
  supply_reset_a: assert property (sup_req [*2] |-> !o_core_resetn) else $error("no reset");
  supply_pin_a: assert property (sup_req [*4] |-> o_pin_oe && !o_pin) else $error("pin free");
  wdog_pulse_a: assert property ($rose(i_watchdog_underflow) && !o_pin_is_gpio
    |-> ##2 (o_pin_oe && !o_pin) [*4]) else $error("short pulse");
  illegal_seq_a: assert property ($rose(i_illegal_opcode) |-> ##[1:3] !o_core_resetn)
    else $error("no illegal reset");
  seq_length_a: assert property ($rose(o_core_resetn)
    |-> low_cnt >= 16'(OUT_PULSE + DELAY_SLOW + 2)) else $error("sequence short");
  gpio_by_write_a: assert property ($rose(o_pin_is_gpio)
    |-> $past(i_wr) || $past(i_wr, 2)) else $error("gpio without write");
  gpio_exit_a: assert property ($fell(o_pin_is_gpio) |-> ##[0:2] !o_core_resetn)
    else $error("gpio left");
  rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00) else $error("rdata");
  cover property ($rose(o_pin_is_gpio));
  cover property (sup_req [*4]);
  cover property ($rose(o_core_resetn));
endmodule // rpm_props
bind rpm_reset_pin_manager rpm_props #(.DELAY_SLOW(DELAY_SLOW), .OUT_PULSE(OUT_PULSE)) i_props (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_supply_low(i_supply_low), .i_supply_detector_en(i_supply_detector_en),
  .i_watchdog_underflow(i_watchdog_underflow), .i_illegal_opcode(i_illegal_opcode),
  .o_pin(o_pin), .o_pin_oe(o_pin_oe), .o_core_resetn(o_core_resetn),
  .o_pin_is_gpio(o_pin_is_gpio));
`default_nettype wire

// [testbench/rpm_board_model.sv]
`timescale 1ns/100ps
`default_nettype none
module rpm_board_model (
  // device side
  input wire logic i_pin_oe,
  input wire logic i_pin_drive,
  // board reset circuit
  input wire logic i_pull_low,
  output logic o_level
);
  // weak pull-up gives the high level when nobody sinks
  assign o_level = !(i_pull_low || (i_pin_oe && !i_pin_drive));
endmodule // rpm_board_model
`default_nettype wire

// [testbench/test_reset_pin_manager.sv]
`timescale 1ns/100ps
`default_nettype none
module test_reset_pin_manager;
  localparam int DF = 8;
  localparam int DS = 4;
  logic i_mclk = 1'b0;
  logic i_resetn = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic sup = 1'b0;
  logic det_en = 1'b1;
  logic wdog = 1'b0;
  logic illegal = 1'b0;
  logic slow = 1'b0;
  logic port_bit = 1'b1;
  logic pull_low = 1'b1;
  logic [7:0] o_rdata;
  logic o_pin, o_pin_oe, o_core_resetn, o_pin_is_gpio, level;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;
  int n_fast;
  int n_slow;
  always #2 i_mclk = ~i_mclk;
  rpm_reset_pin_manager #(.DELAY_FAST(DF), .DELAY_SLOW(DS), .OUT_PULSE(5)) i_dut (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
    .i_rd(i_rd), .o_rdata(o_rdata), .i_supply_low(sup), .i_supply_detector_en(det_en),
    .i_watchdog_underflow(wdog), .i_illegal_opcode(illegal), .i_slow_clock_sel(slow),
    .i_pin(level), .o_pin(o_pin), .o_pin_oe(o_pin_oe), .i_port_a_bit3_output(port_bit),
    .o_core_resetn(o_core_resetn), .o_pin_is_gpio(o_pin_is_gpio));
  rpm_board_model i_board (.i_pin_oe(o_pin_oe), .i_pin_drive(o_pin), .i_pull_low(pull_low),
    .o_level(level));
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // strobe held for one edge, then an idle edge so no signal is driven twice in a step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    @(posedge i_mclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string what);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 check(what, exp, o_rdata);
    @(posedge i_mclk);
  endtask
  // cycles until the core leaves reset; first edge lets launched outputs settle
  task automatic boot(output int n);
    n = 0;
    @(posedge i_mclk);
    while (o_core_resetn !== 1'b1) begin
      @(posedge i_mclk);
      n++;
    end
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_keys();
    rdchk(rpm_pkg::KEY_LOW_OFFSET, 8'h00, "key low");
    wr(rpm_pkg::KEY_LOW_OFFSET, rpm_pkg::KEY_LOW_UNLOCK);
    wr(rpm_pkg::KEY_LOW_OFFSET, 8'h00);
    rdchk(rpm_pkg::KEY_LOW_OFFSET, 8'h55, "key low once");
    check("gpio half", 8'h00, {7'h00, o_pin_is_gpio});
    wr(rpm_pkg::KEY_HIGH_OFFSET, rpm_pkg::KEY_HIGH_UNLOCK);
    repeat (2) @(posedge i_mclk);
    check("gpio on", 8'h01, {7'h00, o_pin_is_gpio});
    check("pin port", 8'h01, {7'h00, level});
    port_bit <= 1'b0;
    repeat (2) @(posedge i_mclk);
    check("pin port low", 8'h00, {7'h00, level});
    port_bit <= 1'b1;
    wr(rpm_pkg::KEY_HIGH_OFFSET, 8'h00);
    check("gpio kept", 8'h01, {7'h00, o_pin_is_gpio});
    rdchk(8'h50, 8'h00, "unmapped");
  endtask
  task automatic t_internal();
    illegal <= 1'b1;
    @(posedge i_mclk);
    illegal <= 1'b0;
    boot(n_fast);
    check("gpio cleared", 8'h00, {7'h00, o_pin_is_gpio});
    rdchk(rpm_pkg::KEY_HIGH_OFFSET, 8'h00, "key high");
    slow <= 1'b1;
    wdog <= 1'b1;
    @(posedge i_mclk);
    wdog <= 1'b0;
    boot(n_slow);
    check("delay step", 8'(DF - DS), 8'(n_fast - n_slow));
    slow <= 1'b0;
  endtask
  task automatic t_supply();
    sup <= 1'b1;
    repeat (10) @(posedge i_mclk);
    check("supply core", 8'h00, {7'h00, o_core_resetn});
    check("supply pin", 8'h00, {7'h00, level});
    sup <= 1'b0;
    boot(n_fast);
    rdchk(rpm_pkg::FLAGS_OFFSET, 8'h04, "flags");
    det_en <= 1'b0;
    sup <= 1'b1;
    repeat (20) @(posedge i_mclk);
    check("detector off", 8'h01, {7'h00, o_core_resetn});
    sup <= 1'b0;
    det_en <= 1'b1;
  endtask
  task automatic t_external();
    pull_low <= 1'b1;
    repeat (6) @(posedge i_mclk);
    check("external", 8'h00, {7'h00, o_core_resetn});
    pull_low <= 1'b0;
    boot(n_fast);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      conclude();
    end
  end
  initial begin
    repeat (10) @(posedge i_mclk);
    i_resetn <= 1'b1;
    repeat (5) @(posedge i_mclk);
    pull_low <= 1'b0;
    boot(n_fast);
    t_keys();
    t_internal();
    t_supply();
    t_external();
    conclude();
  end
endmodule // test_reset_pin_manager
`default_nettype wire
